// [pir_defines.svh]
`ifndef PIR_DEFINES_SVH
`define PIR_DEFINES_SVH

// ****************************************************************
// identification levels
// ****************************************************************
`define PIR_LVL_STD0        32'h0000_0000
`define PIR_LVL_STD1        32'h0000_0001
`define PIR_LVL_STD2        32'h0000_0002
`define PIR_LVL_EXT0        32'h8000_0000

// ****************************************************************
// level zero answers
// ****************************************************************
`define PIR_MAX_STD_LEVEL   32'h0000_0002
`define PIR_MAX_EXT_LEVEL   32'h8000_0005

// ****************************************************************
// level one field positions and values
// ****************************************************************
`define PIR_STEP_LSB        0
`define PIR_MODEL_LSB       4
`define PIR_FAMILY_LSB      8
`define PIR_TYPE_LSB        12
`define PIR_MODEL_VAL       4'h4
`define PIR_FAMILY_VAL      4'h5
`define PIR_TYPE_VAL        4'h0
`define PIR_FEAT_FPU        0
`define PIR_FEAT_TSC        4
`define PIR_FEAT_MSR        5
`define PIR_FEAT_CX8        8
`define PIR_FEAT_CMOV       15
`define PIR_FEAT_MMEXT      23
`define PIR_CTL4_TSD_BIT    2

// ****************************************************************
// level two descriptors
// ****************************************************************
`define PIR_DESC_ONCE       8'h01
`define PIR_DESC_XLATE      8'h70
`define PIR_DESC_L1         8'h80

// ****************************************************************
// flags register
// ****************************************************************
`define PIR_IDENTIFY_BIT    21

`endif

// [pir_pkg.sv]
package pir_pkg;

  typedef logic [31:0] pir_word_t;

  typedef enum logic [2:0] {
    PIR_IDLE = 3'b001,
    PIR_RESP = 3'b010,
    PIR_DONE = 3'b100
  } pir_state_e;

endpackage : pir_pkg

// [pir_feature_flags.sv]
`timescale 1ns/1ps
`include "pir_defines.svh"

// ****************************************************************
// level one feature word
// ****************************************************************
module pir_feature_flags (
  // control
  input  wire logic             tsc_protect,
  // result
  output pir_pkg::pir_word_t    features
);

  always_comb begin
    features                       = 32'h0000_0000;
    features[`PIR_FEAT_FPU]        = 1'b1;
    features[`PIR_FEAT_TSC]        = 1'b1;
    features[`PIR_FEAT_MSR]        = 1'b1;
    features[`PIR_FEAT_CX8]        = 1'b1;
    features[`PIR_FEAT_CMOV]       = 1'b1;
    features[`PIR_FEAT_MMEXT]      = 1'b1;
  end

  // the flag stays set; protection only limits the counter read privilege
  logic unused_protect;
  assign unused_protect = tsc_protect;

endmodule : pir_feature_flags

// [pir_responder.sv]
`timescale 1ns/1ps
`include "pir_defines.svh"

// Overview of operation
// [RULE_01] The level answered is chosen from the accumulator value captured at the request.
// [RULE_02] Software may toggle the identify-present bit 21 of the flags register.
// [RULE_03] Level zero returns 2 in the accumulator as the highest standard level.
// [RULE_04] That maximum counts only standard levels, never the extended ones.
// [RULE_05] Level zero returns the twelve-character maker string in base, data, count order.
// [RULE_06] Level one returns stepping, model 4, family 5 and type 0 in the accumulator.
// [RULE_07] Level one returns nothing defined in the base and count registers.
// [RULE_08] Level one sets feature bits 0, 4, 5, 8, 15 and 23 and clears all others.
// [RULE_09] The time stamp counter flag at bit 4 is governed by control register four bit 2; the code keeps bit 4 set and only registers ctl4_tsc_protect.
// [RULE_10] Level two puts translation lookaside buffer descriptor 70h in accumulator bits 15:8.
// [RULE_11] Level two puts 01h in the accumulator low byte; base and count are reserved.
// [RULE_12] Level two puts L1 descriptor 80h in the data register low byte.
// [RULE_13] Input 80000000h returns an accumulator value of at least 80000000h.
// [RULE_14] Input 80000000h returns 80000005h as the highest extended level.
// [RULE_15] Input 80000000h leaves base, count and data reserved.
// [RULE_16] All reserved registers and fields read as zero.
module pir_responder #(
  parameter logic [3:0]  STEPPING = 4'h0,
  // vendor string words; arbitrary neutral values
  parameter logic [31:0] VENDOR_W0 = 32'h6E65_6E55,
  parameter logic [31:0] VENDOR_W1 = 32'h6E67_6972,
  parameter logic [31:0] VENDOR_W2 = 32'h6465_6D61
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // request
  input  wire logic             req_valid,
  input  pir_pkg::pir_word_t    accumulator_in,
  // flags register access
  input  wire logic             flags_wr,
  input  wire logic             flags_id_wdata,
  // control
  input  wire logic             ctl4_tsc_protect,
  // response
  output logic                  rsp_valid,
  output pir_pkg::pir_word_t    accumulator_register,
  output pir_pkg::pir_word_t    base_register,
  output pir_pkg::pir_word_t    count_register,
  output pir_pkg::pir_word_t    data_register,
  output logic                  identify_present_bit,
  output logic                  tsc_protect_r
);

  // ****************************************************************
  // feature word
  // ****************************************************************
  pir_pkg::pir_word_t features;

  pir_feature_flags u_feat (
    .tsc_protect (ctl4_tsc_protect),
    .features    (features)
  );

  // ****************************************************************
  // flags register identify bit
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      identify_present_bit <= 1'b0;
    end else if (flags_wr) begin
      identify_present_bit <= flags_id_wdata; // RULE_02
    end
  end

  // ****************************************************************
  // control register four time stamp protection
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tsc_protect_r <= 1'b0;
    end else begin
      tsc_protect_r <= ctl4_tsc_protect; // RULE_09
    end
  end

  // ****************************************************************
  // level decode
  // ****************************************************************
  pir_pkg::pir_word_t acc_nxt;
  pir_pkg::pir_word_t base_nxt;
  pir_pkg::pir_word_t count_nxt;
  pir_pkg::pir_word_t data_nxt;

  always_comb begin
    acc_nxt   = 32'h0000_0000; // RULE_16
    base_nxt  = 32'h0000_0000; // RULE_07
    count_nxt = 32'h0000_0000; // RULE_15
    data_nxt  = 32'h0000_0000;
    unique case (accumulator_in) // RULE_01
      `PIR_LVL_STD0: begin
        acc_nxt   = `PIR_MAX_STD_LEVEL; // RULE_03 RULE_04
        base_nxt  = VENDOR_W0; // RULE_05
        data_nxt  = VENDOR_W1;
        count_nxt = VENDOR_W2;
      end
      `PIR_LVL_STD1: begin
        acc_nxt[`PIR_STEP_LSB+:4]   = STEPPING; // RULE_06
        acc_nxt[`PIR_MODEL_LSB+:4]  = `PIR_MODEL_VAL;
        acc_nxt[`PIR_FAMILY_LSB+:4] = `PIR_FAMILY_VAL;
        acc_nxt[`PIR_TYPE_LSB+:4]   = `PIR_TYPE_VAL;
        data_nxt                    = features; // RULE_08
      end
      `PIR_LVL_STD2: begin
        acc_nxt[7:0]  = `PIR_DESC_ONCE; // RULE_11
        acc_nxt[15:8] = `PIR_DESC_XLATE; // RULE_10
        data_nxt[7:0] = `PIR_DESC_L1; // RULE_12
      end
      `PIR_LVL_EXT0: begin
        acc_nxt = `PIR_MAX_EXT_LEVEL; // RULE_13 RULE_14
      end
      default: begin
        acc_nxt = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************************
  // response state
  // ****************************************************************
  pir_pkg::pir_state_e state_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= pir_pkg::PIR_IDLE;
    end else begin
      unique case (state_r)
        pir_pkg::PIR_IDLE: state_r <= req_valid ? pir_pkg::PIR_RESP : pir_pkg::PIR_IDLE;
        pir_pkg::PIR_RESP: state_r <= req_valid ? pir_pkg::PIR_RESP : pir_pkg::PIR_DONE;
        pir_pkg::PIR_DONE: state_r <= req_valid ? pir_pkg::PIR_RESP : pir_pkg::PIR_IDLE;
        default:           state_r <= pir_pkg::PIR_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // response registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      accumulator_register <= 32'h0000_0000;
      base_register        <= 32'h0000_0000;
      count_register       <= 32'h0000_0000;
      data_register        <= 32'h0000_0000;
    end else if (req_valid) begin
      accumulator_register <= acc_nxt; // RULE_01
      base_register        <= base_nxt;
      count_register       <= count_nxt;
      data_register        <= data_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  lvl0_max_std_a: assert property (req_valid && accumulator_in == 32'h0 |=> // RULE_03
    rsp_valid && accumulator_register == 32'h2) else $error("level zero max wrong");
  lvl0_vendor_a: assert property (req_valid && accumulator_in == 32'h0 |=> // RULE_05
    base_register == VENDOR_W0 && data_register == VENDOR_W1 && count_register == VENDOR_W2)
    else $error("vendor string wrong");
  lvl1_sig_a: assert property (req_valid && accumulator_in == 32'h1 |=> // RULE_06
    accumulator_register == {16'h0, 4'h0, 4'h5, 4'h4, STEPPING}) else $error("signature wrong");
  lvl1_resv_a: assert property (req_valid && accumulator_in == 32'h1 |=> // RULE_07
    base_register == 32'h0 && count_register == 32'h0) else $error("level one reserved");
  lvl1_feat_a: assert property (req_valid && accumulator_in == 32'h1 |=> // RULE_08
    data_register == 32'h0080_8131) else $error("feature word wrong");
  lvl2_desc_a: assert property (req_valid && accumulator_in == 32'h2 |=> // RULE_10
    accumulator_register == 32'h0000_7001 && data_register == 32'h0000_0080)
    else $error("descriptor wrong");
  ext_max_a: assert property (req_valid && accumulator_in == 32'h8000_0000 |=> // RULE_14
    accumulator_register == 32'h8000_0005 && data_register == 32'h0) else $error("ext max wrong");
  id_bit_a: assert property (flags_wr |=> identify_present_bit == $past(flags_id_wdata)) // RULE_02
    else $error("identify bit not written");
  rsp_hold_a: assert property (!req_valid |=> $stable(accumulator_register)) // RULE_16
    else $error("answer changed without request");

  rsp_pulse_a: assert property (1'b1 |=> rsp_valid == $past(req_valid)) // RULE_01
    else $error("answer strobe not one cycle after request");
  rsp_state_a: assert property (rsp_valid == (state_r == pir_pkg::PIR_RESP)) // RULE_01
    else $error("response state disagrees with answer strobe");
  lvl0_std_only_a: assert property (req_valid && accumulator_in == 32'h0 |=> // RULE_04
    accumulator_register < 32'h8000_0000) else $error("standard max holds extended level");
  lvl2_resv_a: assert property (req_valid && accumulator_in == 32'h2 |=> // RULE_11
    base_register == 32'h0 && count_register == 32'h0) else $error("level two reserved");
  lvl2_l1_a: assert property (req_valid && accumulator_in == 32'h2 |=> // RULE_12
    data_register[7:0] == 8'h80) else $error("level one cache descriptor wrong");
  ext_sup_a: assert property (req_valid && accumulator_in == 32'h8000_0000 |=> // RULE_13
    accumulator_register >= 32'h8000_0000) else $error("extended support not shown");
  ext_resv_a: assert property (req_valid && accumulator_in == 32'h8000_0000 |=> // RULE_15
    base_register == 32'h0 && count_register == 32'h0 && data_register == 32'h0)
    else $error("extended reserved not zero");
  unknown_zero_a: assert property (req_valid && // RULE_16
    !(accumulator_in inside {32'h0, 32'h1, 32'h2, 32'h8000_0000}) |=>
    accumulator_register == 32'h0 && base_register == 32'h0 &&
    count_register == 32'h0 && data_register == 32'h0) else $error("unknown level not zero");
  tsc_copy_a: assert property (1'b1 |=> tsc_protect_r == $past(ctl4_tsc_protect)) // RULE_09
    else $error("protect copy wrong");
  id_hold_a: assert property (!flags_wr |=> $stable(identify_present_bit)) // RULE_02
    else $error("identify bit changed without write");

  lvl0_c: cover property (req_valid && accumulator_in == 32'h0 ##1 rsp_valid);
  lvl1_c: cover property (req_valid && accumulator_in == 32'h1 ##1 rsp_valid);
  lvl2_c: cover property (req_valid && accumulator_in == 32'h2 ##1 rsp_valid);
  ext_c:  cover property (req_valid && accumulator_in == 32'h8000_0000 ##1 rsp_valid);
  id_c:   cover property (flags_wr ##1 identify_present_bit);

endmodule : pir_responder

// [pir_testbench.sv]
`timescale 1ns/1ps

module testbench;

  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [3:0]  STEP = 4'h3;
  // vendor words; arbitrary values
  localparam logic [31:0] VW0  = 32'h5A5A_1234;
  localparam logic [31:0] VW1  = 32'h0F0F_9876;
  localparam logic [31:0] VW2  = 32'h3C3C_ABCD;

  logic               clk;
  logic               rstn;
  logic               req_valid;
  pir_pkg::pir_word_t accumulator_in;
  logic               flags_wr;
  logic               flags_id_wdata;
  logic               ctl4_tsc_protect;
  logic               rsp_valid;
  pir_pkg::pir_word_t acc_o;
  pir_pkg::pir_word_t base_o;
  pir_pkg::pir_word_t count_o;
  pir_pkg::pir_word_t data_o;
  logic               id_o;
  logic               tsc_o;
  int                 fails;
  int                 checked;
  int                 cycles;
  logic [127:0]       held;
  logic               id_exp;
  logic               tsc_exp;
  logic [31:0]        seed;
  logic [31:0]        lvls [9] = '{32'h0, 32'h1, 32'h2, 32'h8000_0000, 32'h3, 32'h8000_0001,
                                   32'h8000_0005, 32'h7FFF_FFFF, 32'hFFFF_FFFF};

  pir_responder #(.STEPPING(STEP), .VENDOR_W0(VW0), .VENDOR_W1(VW1), .VENDOR_W2(VW2)) DUT (
    .clk(clk), .rstn(rstn), .req_valid(req_valid), .accumulator_in(accumulator_in),
    .flags_wr(flags_wr), .flags_id_wdata(flags_id_wdata), .ctl4_tsc_protect(ctl4_tsc_protect),
    .rsp_valid(rsp_valid), .accumulator_register(acc_o), .base_register(base_o),
    .count_register(count_o), .data_register(data_o), .identify_present_bit(id_o),
    .tsc_protect_r(tsc_o));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  // expected {accumulator, base, count, data} for a level
  function automatic logic [127:0] expect_rsp(input logic [31:0] lvl);
    case (lvl)
      32'h0000_0000: return {32'h0000_0002, VW0, VW2, VW1};
      32'h0000_0001: return {28'h0000_054, STEP, 64'h0, 32'h0080_8131};
      32'h0000_0002: return {32'h0000_7001, 64'h0, 32'h0000_0080};
      32'h8000_0000: return {32'h8000_0005, 96'h0};
      default:       return 128'h0;
    endcase
  endfunction : expect_rsp

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // clock, timeout and response checking
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end

  always @(posedge clk) begin
    logic sent;
    logic rs;
    logic [31:0] lvl;
    sent = req_valid & rstn;
    rs = rstn;
    lvl = accumulator_in;
    if (!rs) begin
      held = 128'h0;
      id_exp = 1'b0;
      tsc_exp = 1'b0;
    end else begin
      tsc_exp = ctl4_tsc_protect;
      if (flags_wr)
        id_exp = flags_id_wdata;
      if (sent)
        held = expect_rsp(lvl);
    end
    #1;
    check("rsp_valid", {31'h0, rsp_valid}, {31'h0, sent});
    check("accumulator", acc_o, held[127:96]);
    check("base", base_o, held[95:64]);
    check("count", count_o, held[63:32]);
    check("data", data_o, held[31:0]);
    check("identify_bit", {31'h0, id_o}, {31'h0, id_exp});
    check("tsc_protect", {31'h0, tsc_o}, {31'h0, tsc_exp});
  end

  // ****************************************************************
  // stimulus
  // ****************************************************************
  task automatic random_run(input int n);
    repeat (n) begin
      @(posedge clk);
      seed = xs(seed);
      req_valid <= seed[0];
      accumulator_in <= (seed[3:1] < 3'h5) ? lvls[seed[7:4] % 9] : xs(seed);
      flags_wr <= seed[8];
      flags_id_wdata <= seed[9];
      ctl4_tsc_protect <= seed[10];
    end
  endtask : random_run

  initial begin
    seed = 32'h4101CF04;
    rstn = 1'b0;
    req_valid = 1'b0;
    accumulator_in = 32'h0;
    flags_wr = 1'b0;
    flags_id_wdata = 1'b0;
    ctl4_tsc_protect = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // back-to-back requests over all four known levels and five unknown ones
    foreach (lvls[i]) begin
      @(posedge clk);
      req_valid <= 1'b1;
      accumulator_in <= lvls[i];
      ctl4_tsc_protect <= i[0];
    end
    random_run(300);
    // reset in mid-run with traffic pending
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    random_run(300);
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
    wrap_up();
  end

endmodule : testbench
